/* File: hw/tcoc_top.v */
// Compare-output waveform control for a 16-bit timer, three channels.
// Assumes the timer core supplies tick, count, direction, TOP and BOTTOM.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`include "tcoc_consts.vh"
module tcoc_top (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire [1:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire        timer_tick,
   input  wire [15:0] counter_value,
   input  wire [15:0] top_value,
   input  wire        at_bottom,
   input  wire        count_down,
   input  wire [15:0] compare_value_a,
   input  wire [15:0] compare_value_b,
   input  wire [15:0] compare_value_c,
   input  wire [2:0]  pin_dir_out,
   output wire        compare_out_a,
   output wire        compare_out_b,
   output wire        compare_out_c,
   output wire [2:0]  pin_override,
   output wire [2:0]  pin_drive_en
);
   reg  [7:0]  ctrl_ff;
   reg  [1:0]  wgm_upper_ff;
   reg         ack_ff;
   wire [3:0]  waveform_mode_select;
   wire [1:0]  mode_kind;
   wire        acc;
   wire        wr_ok;
   wire        tog_a;
   wire [2:0]  cout;

   // One wait cycle per access keeps readdata registered
   assign acc             = avs_read | avs_write;
   assign avs_waitrequest = acc & ~ack_ff;
   // Writes commit only at the completing edge, never while still waiting
   assign wr_ok           = avs_write & ack_ff & avs_byteenable[0];

   assign waveform_mode_select = {wgm_upper_ff, ctrl_ff[`TCOC_WGM_HI:`TCOC_WGM_LO]};

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff      <= `TCOC_CTRL_RESET;
         wgm_upper_ff <= `TCOC_UPPER_RESET;
         ack_ff       <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         ack_ff <= acc & ~ack_ff;
         if (wr_ok && avs_address == `TCOC_ADDR_CTRL)
            ctrl_ff <= avs_writedata[7:0];
         if (wr_ok && avs_address == `TCOC_ADDR_WGM_UPPER)
            wgm_upper_ff <= avs_writedata[1:0];
         if (avs_read && !ack_ff) begin
            case (avs_address)
               `TCOC_ADDR_CTRL:      avs_readdata <= {24'h000000, ctrl_ff};
               `TCOC_ADDR_WGM_UPPER: avs_readdata <= {30'h0, wgm_upper_ff};
               `TCOC_ADDR_STATUS:    avs_readdata <= {26'h0, pin_override, cout};
               default:              avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   tcoc_mode_decode u_dec (
      .waveform_mode_select (waveform_mode_select),
      .mode_kind            (mode_kind)
   );

   // Only channel A may toggle in PWM modes, and only where TOP is its compare
   assign tog_a = (waveform_mode_select == `TCOC_WGM_FAST_A) ||
                  (waveform_mode_select == `TCOC_WGM_PFC_A) ||
                  (waveform_mode_select == `TCOC_WGM_PC_A);

   tcoc_channel u_ch_a (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .timer_tick     (timer_tick),
      .counter_value  (counter_value),
      .compare_value  (compare_value_a),
      .top_value      (top_value),
      .at_bottom      (at_bottom),
      .count_down     (count_down),
      .output_mode    (ctrl_ff[`TCOC_A_HI:`TCOC_A_LO]),
      .mode_kind      (mode_kind),
      .toggle_allowed (tog_a),
      .pin_dir_out    (pin_dir_out[0]),
      .compare_out    (cout[0]),
      .pin_override   (pin_override[0]),
      .pin_drive_en   (pin_drive_en[0])
   );

   tcoc_channel u_ch_b (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .timer_tick     (timer_tick),
      .counter_value  (counter_value),
      .compare_value  (compare_value_b),
      .top_value      (top_value),
      .at_bottom      (at_bottom),
      .count_down     (count_down),
      .output_mode    (ctrl_ff[`TCOC_B_HI:`TCOC_B_LO]),
      .mode_kind      (mode_kind),
      .toggle_allowed (1'b0),
      .pin_dir_out    (pin_dir_out[1]),
      .compare_out    (cout[1]),
      .pin_override   (pin_override[1]),
      .pin_drive_en   (pin_drive_en[1])
   );

   tcoc_channel u_ch_c (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .timer_tick     (timer_tick),
      .counter_value  (counter_value),
      .compare_value  (compare_value_c),
      .top_value      (top_value),
      .at_bottom      (at_bottom),
      .count_down     (count_down),
      .output_mode    (ctrl_ff[`TCOC_C_HI:`TCOC_C_LO]),
      .mode_kind      (mode_kind),
      .toggle_allowed (1'b0),
      .pin_dir_out    (pin_dir_out[2]),
      .compare_out    (cout[2]),
      .pin_override   (pin_override[2]),
      .pin_drive_en   (pin_drive_en[2])
   );

   assign compare_out_a = cout[0];
   assign compare_out_b = cout[1];
   assign compare_out_c = cout[2];
endmodule // tcoc_top

/* File: shared/tcoc_consts.vh */
// Constants for the timer compare-output control block.
// Included by every design file; definitions only.
`ifndef TCOC_CONSTS_VH
`define TCOC_CONSTS_VH
`define TCOC_ADDR_CTRL      2'h0
`define TCOC_ADDR_WGM_UPPER 2'h1
`define TCOC_ADDR_STATUS    2'h2
`define TCOC_CTRL_RESET     8'h00
`define TCOC_UPPER_RESET    2'h0
`define TCOC_A_HI           7
`define TCOC_A_LO           6
`define TCOC_B_HI           5
`define TCOC_B_LO           4
`define TCOC_C_HI           3
`define TCOC_C_LO           2
`define TCOC_WGM_HI         1
`define TCOC_WGM_LO         0
`define TCOC_COM_OFF        2'h0
`define TCOC_COM_TOGGLE     2'h1
`define TCOC_COM_CLEAR      2'h2
`define TCOC_COM_SET        2'h3
`define TCOC_WGM_FAST_A     4'hF
`define TCOC_WGM_PFC_A      4'h9
`define TCOC_WGM_PC_A       4'hB
`define TCOC_KIND_NONPWM    2'h0
`define TCOC_KIND_FAST      2'h1
`define TCOC_KIND_DUAL      2'h2
`endif

/* File: hw/tcoc_mode_decode.v */
// Classifies the four-bit waveform mode into non-PWM, fast PWM or dual-slope.
// Assumes a plain combinational use by the channel logic.
`timescale 1ns/10ps
`include "tcoc_consts.vh"
module tcoc_mode_decode (
   input  wire [3:0] waveform_mode_select,
   output reg  [1:0] mode_kind
);
   always @* begin
      case (waveform_mode_select)
         4'h0, 4'h4, 4'hC, 4'hD: mode_kind = `TCOC_KIND_NONPWM;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_kind = `TCOC_KIND_FAST;
         default: mode_kind = `TCOC_KIND_DUAL;
      endcase
   end
endmodule // tcoc_mode_decode

/* File: hw/tcoc_channel.v */
// One compare-output channel: match detect, output flip-flop, pin override.
// Assumes counter, TOP, BOTTOM and direction come from the timer core.
`timescale 1ns/10ps
`include "tcoc_consts.vh"
module tcoc_channel (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        timer_tick,
   input  wire [15:0] counter_value,
   input  wire [15:0] compare_value,
   input  wire [15:0] top_value,
   input  wire        at_bottom,
   input  wire        count_down,
   input  wire [1:0]  output_mode,
   input  wire [1:0]  mode_kind,
   input  wire        toggle_allowed,
   input  wire        pin_dir_out,
   output wire        compare_out,
   output wire        pin_override,
   output wire        pin_drive_en
);
   reg  out_ff;
   reg  nxt_out;
   wire match;
   wire active;
   assign match = (counter_value == compare_value);
   // Toggle codes in PWM modes only count where the mode permits it
   assign active = (output_mode[1] | output_mode[0]) &
                   ((mode_kind == `TCOC_KIND_NONPWM) | output_mode[1] | toggle_allowed);
   assign pin_override = active;
   assign pin_drive_en = active & pin_dir_out;
   assign compare_out  = out_ff;
   always @* begin
      nxt_out = out_ff;
      case (mode_kind)
         `TCOC_KIND_FAST: begin
            if (output_mode[1]) begin
               // Match at TOP is ignored so BOTTOM action alone decides
               if (at_bottom)
                  nxt_out = ~output_mode[0];
               else if (match && (compare_value != top_value))
                  nxt_out = output_mode[0];
            end else if (output_mode[0] && toggle_allowed && match) begin
               nxt_out = ~out_ff;
            end
         end
         `TCOC_KIND_DUAL: begin
            if (output_mode[1]) begin
               // Compare at BOTTOM or TOP pins the level steadily
               if (compare_value == 16'h0000)
                  nxt_out = output_mode[0];
               else if (compare_value == top_value)
                  nxt_out = ~output_mode[0];
               else if (match)
                  nxt_out = count_down ? ~output_mode[0] : output_mode[0];
            end else if (output_mode[0] && toggle_allowed && match) begin
               nxt_out = ~out_ff;
            end
         end
         default: begin
            if (match) begin
               case (output_mode)
                  `TCOC_COM_TOGGLE: nxt_out = ~out_ff;
                  `TCOC_COM_CLEAR:  nxt_out = 1'b0;
                  `TCOC_COM_SET:    nxt_out = 1'b1;
                  default:          nxt_out = out_ff;
               endcase
            end
         end
      endcase
   end
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         out_ff <= 1'b0;
      else if (timer_tick)
         out_ff <= nxt_out;
   end
endmodule // tcoc_channel

/* File: test/tcoc_chk.sv */
// Assertions on the compare-output block, watching only its top ports.
// Assumes a register write lands on the edge where waitrequest is low.
`timescale 1ns/10ps
module tcoc_chk (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [1:0]  avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   input wire logic        timer_tick,
   input wire logic [15:0] counter_value,
   input wire logic [15:0] top_value,
   input wire logic        at_bottom,
   input wire logic        count_down,
   input wire logic [15:0] compare_value_a,
   input wire logic [2:0]  pin_dir_out,
   input wire logic        compare_out_a,
   input wire logic [2:0]  pin_override,
   input wire logic [2:0]  pin_drive_en
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [7:0] ctrl_ff;
   logic [1:0] upper_ff;
   // Shadow copy of the registers, so no view inside the block is needed
   wire [3:0] wgm  = {upper_ff, ctrl_ff[1:0]};
   wire       fast = wgm[2] & (wgm[1] | wgm[0]) & (wgm != 4'hD);
   wire       dual = ~wgm[2] & (|wgm);
   wire [1:0] ca   = ctrl_ff[7:6];
   wire       ca_lo = ctrl_ff[6];
   wire       hit  = timer_tick && counter_value == compare_value_a;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff  <= 8'h00;
         upper_ff <= 2'h0;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
         if (avs_address == 2'h0) ctrl_ff <= avs_writedata[7:0];
         if (avs_address == 2'h1) upper_ff <= avs_writedata[1:0];
      end
   end
   drive_gate_a: assert property (pin_drive_en == (pin_override & pin_dir_out))
      else $error("drive enable wrong");
   port_claim_a: assert property (ca != 2'h1 |-> pin_override[0] == (|ca))
      else $error("pin claim wrong");
   fast_quiet_a: assert property (fast && ctrl_ff[5:4] == 2'h1 |-> !pin_override[1])
      else $error("B claimed in fast PWM");
   idle_hold_a: assert property (!timer_tick |=> $stable(compare_out_a))
      else $error("output moved without tick");
   plain_hit_a: assert property (hit && !fast && !dual && ca[1]
      |=> compare_out_a == $past(ca_lo)) else $error("match action wrong");
   fast_bottom_a: assert property (timer_tick && at_bottom && fast && ca[1]
      |=> compare_out_a != $past(ca_lo)) else $error("bottom action wrong");
   top_skip_a: assert property (timer_tick && !at_bottom && fast && ca[1]
      && compare_value_a == top_value |=> $stable(compare_out_a)) else $error("TOP match acted");
   dual_hit_a: assert property (hit && dual && ca[1] && compare_value_a != 16'h0000
      && compare_value_a != top_value |=> compare_out_a == ($past(ca_lo) ^ $past(count_down)))
      else $error("dual-slope match wrong");
endmodule // tcoc_chk
bind tcoc_top tcoc_chk chk_u (.sys_clk, .sys_rst, .avs_address, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_waitrequest, .timer_tick, .counter_value, .top_value, .at_bottom,
   .count_down, .compare_value_a, .pin_dir_out, .compare_out_a, .pin_override, .pin_drive_en);

/* File: test/tcoc_pin_model.sv */
// Port pin model: a general-purpose pin that the compare channels may claim.
// Assumes a pull-up holds an undriven pin high.
`timescale 1ns/10ps
module tcoc_pin_model (
   input  wire logic [2:0] port_data,
   input  wire logic [2:0] port_dir,
   input  wire logic [2:0] compare_out,
   input  wire logic [2:0] pin_override,
   input  wire logic [2:0] pin_drive_en,
   output wire logic [2:0] pin_level
);
   // A claimed pin shows the compare flop only through an enabled driver
   assign pin_level = (pin_drive_en & compare_out) | (~pin_override & port_dir & port_data)
      | ~port_dir;
endmodule // tcoc_pin_model

/* File: test/tb_top.sv */
// Bench for the compare-output block: registers, pin claim, all waveform kinds.
// Assumes output updates on timer ticks; every bus wait is bounded.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
   logic        sys_clk, sys_rst, avs_read, avs_write, timer_tick, at_bottom, count_down;
   logic [1:0]  avs_address;
   logic [31:0] avs_writedata, q;
   logic [3:0]  avs_byteenable;
   logic [15:0] counter_value, top_value, cmp;
   logic [2:0]  pin_dir_out, port_data;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire  [2:0]  outs, pin_override, pin_drive_en, pin_level;
   int          n_errors = 0, num_checks = 0;
   tcoc_top dut_u (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_tick, .counter_value, .top_value,
      .at_bottom, .count_down, .compare_value_a(cmp), .compare_value_b(cmp),
      .compare_value_c(cmp), .pin_dir_out, .compare_out_a(outs[0]), .compare_out_b(outs[1]),
      .compare_out_c(outs[2]), .pin_override, .pin_drive_en);
   tcoc_pin_model pin_u (.port_data, .port_dir(pin_dir_out), .compare_out(outs), .pin_override,
      .pin_drive_en, .pin_level);
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 20) begin
         n_errors++;
         test_done();
      end
      q = avs_readdata;
      {avs_write, avs_read} <= 2'h0;
   endtask
   task automatic cfg(input logic [7:0] c, input logic [1:0] u);
      bus(1'b1, 2'h1, {30'h0, u});
      bus(1'b1, 2'h0, {24'h0, c});
      // The write lands at the completing edge, so let one edge pass
      @(posedge sys_clk);
   endtask
   // Outputs are judged half a cycle after the tick edge, once settled
   task automatic tick(input logic [15:0] c, input logic dn, bt, input logic [2:0] e);
      @(posedge sys_clk);
      {counter_value, count_down, at_bottom, timer_tick} <= {c, dn, bt, 1'b1};
      @(posedge sys_clk);
      timer_tick <= 1'b0;
      @(negedge sys_clk);
      `CHK(outs, e)
   endtask
   task automatic t_regs;
      bus(1'b0, 2'h0, 32'h0);
      `CHK(q, 32'h0)
      cfg(8'hE4, 2'h3);
      avs_byteenable <= 4'h0;
      bus(1'b1, 2'h0, 32'h0);
      avs_byteenable <= 4'hF;
      bus(1'b1, 2'h3, 32'hFF);
      bus(1'b0, 2'h0, 32'h0);
      `CHK(q, 32'hE4)
      bus(1'b0, 2'h1, 32'h0);
      `CHK(q, 32'h3)
      bus(1'b0, 2'h2, 32'h0);
      `CHK(q, 32'h38)
      bus(1'b0, 2'h3, 32'h0);
      `CHK(q, 32'h0)
   endtask
   task automatic t_pins;
      cfg(8'h8C, 2'h0);
      `CHK({pin_override, pin_drive_en, pin_level}, 9'h14C)
   endtask
   task automatic t_plain;
      logic [2:0] e;
      e = 3'h0;
      for (int k = 3; k > 0; k--) begin
         cfg({{3{k[1:0]}}, 2'h0}, 2'h0);
         e = (k == 1) ? ~e : {3{k[0]}};
         tick(cmp, 1'b0, 1'b0, e);
      end
      tick(cmp + 16'h1, 1'b0, 1'b0, e);
      cfg(8'h00, 2'h0);
      `CHK(pin_override, 3'h0)
   endtask
   task automatic t_fast;
      cfg(8'hAB, 2'h3);
      tick(16'h0, 1'b0, 1'b1, 3'h7);
      tick(cmp, 1'b0, 1'b0, 3'h0);
      cfg(8'hFF, 2'h3);
      tick(16'h0, 1'b0, 1'b1, 3'h0);
      tick(cmp, 1'b0, 1'b0, 3'h7);
      cfg(8'hFF, 2'h3);
      top_value <= cmp;
      tick(16'h0, 1'b0, 1'b1, 3'h0);
      tick(cmp, 1'b0, 1'b0, 3'h0);
      cfg(8'h57, 2'h3);
      top_value <= 16'h00FF;
      tick(cmp, 1'b0, 1'b0, 3'h1);
      cfg(8'h56, 2'h3);
      `CHK(pin_override, 3'h0)
   endtask
   task automatic t_dual;
      cfg(8'hA9, 2'h2);
      tick(cmp, 1'b0, 1'b0, 3'h0);
      tick(cmp, 1'b1, 1'b0, 3'h7);
      cfg(8'hFD, 2'h2);
      tick(cmp, 1'b1, 1'b0, 3'h0);
      tick(cmp, 1'b0, 1'b0, 3'h7);
      cfg(8'h55, 2'h2);
      tick(cmp, 1'b0, 1'b0, 3'h6);
      cfg(8'h54, 2'h2);
      `CHK(pin_override, 3'h0)
      cfg(8'hA9, 2'h2);
      cmp <= 16'h0;
      tick(16'h5, 1'b0, 1'b0, 3'h0);
      cfg(8'hAB, 2'h2);
      cmp <= 16'h00FF;
      tick(16'h5, 1'b0, 1'b0, 3'h7);
      cfg(8'h57, 2'h2);
      tick(16'h00FF, 1'b1, 1'b0, 3'h6);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      {sys_rst, avs_read, avs_write, timer_tick, at_bottom, count_down} = 6'h20;
      {avs_address, avs_writedata, avs_byteenable} = {2'h0, 32'h0, 4'hF};
      {counter_value, top_value, cmp} = {16'h0, 16'h00FF, 16'h0010};
      {pin_dir_out, port_data} = 6'h18;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_pins();
      t_plain();
      t_fast();
      t_dual();
      test_done();
   end
endmodule // tb_top
